/* File: logic/sdb_pkg.sv */
// package: sdram burst-access constants, carrier types and decode helpers
package sdb_pkg;

  localparam int ADDR_W     = 13;
  localparam int COL_W      = 9;
  localparam int IDX_W      = 9;
  localparam int BANK_W     = 2;
  localparam int NUM_BANKS  = 4;
  localparam int DQ_W       = 16;
  localparam int BYTE_W     = 8;
  localparam int NUM_BYTES  = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int MEM_WORDS  = NUM_BANKS * (1 << COL_W);

  // address pin positions
  localparam int AP_BIT     = 10;
  localparam int MR_BL_LSB  = 0;
  localparam int MR_BT_BIT  = 3;
  localparam int MR_CL_LSB  = 4;

  localparam logic [2:0] BL_CODE_1    = 3'h0;
  localparam logic [2:0] BL_CODE_2    = 3'h1;
  localparam logic [2:0] BL_CODE_4    = 3'h2;
  localparam logic [2:0] BL_CODE_8    = 3'h3;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [2:0] CL_CODE_2    = 3'h2;
  localparam logic [2:0] CL_CODE_3    = 3'h3;

  // write recovery before auto-precharge, in clocks
  localparam logic [1:0] WR_RECOVERY_CYC = 2'h2;

  typedef enum logic [2:0] {
    SDB_CMD_NOP   = 3'h0,
    SDB_CMD_ACT   = 3'h1,
    SDB_CMD_WRITE = 3'h3,
    SDB_CMD_READ  = 3'h2,
    SDB_CMD_STOP  = 3'h6,
    SDB_CMD_PRE   = 3'h7,
    SDB_CMD_MRS   = 3'h5,
    SDB_CMD_REF   = 3'h4
  } sdb_cmd_e;

  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
  } sdb_pins_s;

  typedef struct packed {
    logic [2:0] cas_latency;
    logic       interleave;
    logic [2:0] burst_len;
  } sdb_mode_s;

  localparam sdb_mode_s MODE_RST = '{cas_latency: CL_CODE_2, interleave: 1'b0,
                                     burst_len: BL_CODE_1};

  typedef struct packed {
    logic [BANK_W-1:0]    bank;
    logic [COL_W-1:0]     col;
    logic [NUM_BYTES-1:0] be;
    logic [DQ_W-1:0]      data;
  } sdb_beat_s;

  function automatic sdb_cmd_e sdb_decode(input sdb_pins_s p);
    sdb_cmd_e c;
    c = SDB_CMD_NOP;
    if (!p.cs_b) begin
      unique case ({p.ras_b, p.cas_b, p.we_b})
        3'h0: c = SDB_CMD_MRS;
        3'h1: c = SDB_CMD_REF;
        3'h2: c = SDB_CMD_PRE;
        3'h3: c = SDB_CMD_ACT;
        3'h4: c = SDB_CMD_WRITE;
        3'h5: c = SDB_CMD_READ;
        3'h6: c = SDB_CMD_STOP;
        3'h7: c = SDB_CMD_NOP;
      endcase
    end
    return c;
  endfunction : sdb_decode

  function automatic logic [IDX_W-1:0] sdb_burst_mask(input logic [2:0] code);
    logic [IDX_W-1:0] m;
    unique case (code)
      BL_CODE_2:    m = 9'h001;
      BL_CODE_4:    m = 9'h003;
      BL_CODE_8:    m = 9'h007;
      BL_CODE_FULL: m = 9'h1FF;
      default:      m = 9'h000;
    endcase
    return m;
  endfunction : sdb_burst_mask

  // full page never ends on its own
  function automatic logic sdb_burst_last(input logic [2:0] code, input logic [IDX_W-1:0] idx);
    return (code != BL_CODE_FULL) && (idx == sdb_burst_mask(code));
  endfunction : sdb_burst_last

endpackage : sdb_pkg

/* File: logic/sdb_colgen.sv */
// column address of one burst beat
`timescale 1ns/10ps
module sdb_colgen (
  input  wire logic [sdb_pkg::COL_W-1:0] i_start,
  input  wire logic [sdb_pkg::IDX_W-1:0] i_idx,
  input  wire sdb_pkg::sdb_mode_s        i_mode,
  output logic      [sdb_pkg::COL_W-1:0] o_col
);
  import sdb_pkg::*;

  logic [IDX_W-1:0] mask;
  logic [COL_W-1:0] low;

  always_comb begin
    mask = sdb_burst_mask(i_mode.burst_len);
    if (i_mode.interleave && (i_mode.burst_len != BL_CODE_FULL)) begin
      low = i_start ^ i_idx;
    end else begin
      low = i_start + i_idx;
    end
    o_col = (i_start & ~mask) | (low & mask);
  end

endmodule : sdb_colgen

/* File: logic/sdb_fifo.sv */
// small fifo for write beats on their way to the array
`timescale 1ns/10ps
module sdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  assign o_ready = (count != (PTR_W+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = store[rd_ptr];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      store[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

endmodule : sdb_fifo

/* File: logic/sdb_core.sv */
// sdram command decode, burst engines, auto-precharge and data array
`timescale 1ns/10ps
module sdb_core (
  input  wire logic                              i_clock,
  input  wire logic                              i_rst_b,
  input  wire logic                              i_cke,
  input  wire sdb_pkg::sdb_pins_s                i_cmd,
  input  wire logic     [sdb_pkg::BANK_W-1:0]    i_bank_select,
  input  wire logic     [sdb_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic     [sdb_pkg::NUM_BYTES-1:0] i_dqm,
  input  wire logic     [sdb_pkg::DQ_W-1:0]      i_dq,
  output logic          [sdb_pkg::DQ_W-1:0]      o_dq,
  output logic          [sdb_pkg::NUM_BYTES-1:0] o_dq_oe,
  output logic          [sdb_pkg::NUM_BANKS-1:0] o_bank_open,
  output sdb_pkg::sdb_mode_s                     o_mode,
  output logic                                   o_read_busy,
  output logic                                   o_write_busy,
  output logic                                   o_write_stall
);
  import sdb_pkg::*;

  // command qualification
  logic                 cke_q;
  logic                 cmd_ok;
  sdb_cmd_e             cmd;
  logic                 is_read;
  logic                 is_write;
  logic                 is_stop;
  logic                 is_pre;
  logic                 is_act;
  logic                 is_mrs;
  logic                 pre_all;
  logic [COL_W-1:0]     cmd_col;
  logic                 cmd_ap;

  // read engine
  logic                 rd_act;
  logic [BANK_W-1:0]    rd_bank;
  logic [COL_W-1:0]     rd_start;
  logic [IDX_W-1:0]     rd_idx;
  logic                 rd_ap;
  logic                 rd_last;
  logic [COL_W-1:0]     rd_col;

  // write engine
  logic                 wr_act;
  logic [BANK_W-1:0]    wr_bank;
  logic [COL_W-1:0]     wr_start;
  logic [IDX_W-1:0]     wr_idx;
  logic                 wr_ap;
  logic                 wr_beat;
  logic [BANK_W-1:0]    beat_bank;
  logic [COL_W-1:0]     beat_start;
  logic [IDX_W-1:0]     beat_idx;
  logic                 beat_ap;
  logic                 beat_last;
  logic [COL_W-1:0]     wr_col;

  // write recovery before auto-precharge
  logic [1:0]           rec_cnt;
  logic [BANK_W-1:0]    rec_bank;

  // write beat fifo
  sdb_beat_s            beat_in;
  sdb_beat_s            beat_out;
  logic                 fifo_in_valid;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;

  // data array and read pipeline
  logic [DQ_W-1:0]      mem [0:MEM_WORDS-1];
  logic [DQ_W-1:0]      s1_data;
  logic                 s1_valid;
  logic [DQ_W-1:0]      s2_data;
  logic                 s2_valid;
  logic [NUM_BYTES-1:0] dqm_d1;
  logic [NUM_BYTES-1:0] dqm_d2;
  logic                 lat3;
  logic [DQ_W-1:0]      next_dq;
  logic                 next_valid;

  // decode
  always_comb begin
    cmd_ok   = i_cke && cke_q;
    cmd      = cmd_ok ? sdb_decode(i_cmd) : SDB_CMD_NOP;
    is_read  = (cmd == SDB_CMD_READ);
    is_write = (cmd == SDB_CMD_WRITE);
    is_stop  = (cmd == SDB_CMD_STOP);
    is_pre   = (cmd == SDB_CMD_PRE);
    is_act   = (cmd == SDB_CMD_ACT);
    is_mrs   = (cmd == SDB_CMD_MRS);
    pre_all  = i_addr[AP_BIT];
    cmd_col  = i_addr[COL_W-1:0];
    cmd_ap   = i_addr[AP_BIT];
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= i_cke;
    end
  end

  // mode register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mode <= MODE_RST;
    end else if (is_mrs) begin
      o_mode.burst_len   <= i_addr[MR_BL_LSB +: 3];
      o_mode.interleave  <= i_addr[MR_BT_BIT];
      o_mode.cas_latency <= i_addr[MR_CL_LSB +: 3];
    end
  end

  // read burst engine
  assign rd_last = sdb_burst_last(o_mode.burst_len, rd_idx);

  sdb_colgen u_rd_colgen (
    .i_start (rd_start),
    .i_idx   (rd_idx),
    .i_mode  (o_mode),
    .o_col   (rd_col)
  );

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_act   <= 1'b0;
      rd_bank  <= '0;
      rd_start <= '0;
      rd_idx   <= '0;
      rd_ap    <= 1'b0;
    end else if (is_read) begin
      rd_act   <= 1'b1;
      rd_bank  <= i_bank_select;
      rd_start <= cmd_col;
      rd_idx   <= '0;
      rd_ap    <= cmd_ap;
    end else if (is_write || is_stop) begin
      rd_act <= 1'b0;
    end else if (is_pre && (pre_all || (i_bank_select == rd_bank))) begin
      rd_act <= 1'b0;
    end else if (rd_act) begin
      rd_idx <= rd_idx + 1'b1;
      if (rd_last) begin
        rd_act <= 1'b0;
      end
    end
  end

  // write burst engine; beat 0 rides with the command
  always_comb begin
    wr_beat    = is_write || (wr_act && !is_read && !is_stop && !is_pre);
    beat_bank  = is_write ? i_bank_select : wr_bank;
    beat_start = is_write ? cmd_col : wr_start;
    beat_idx   = is_write ? '0 : wr_idx;
    beat_ap    = is_write ? cmd_ap : wr_ap;
    beat_last  = sdb_burst_last(o_mode.burst_len, beat_idx);
  end

  sdb_colgen u_wr_colgen (
    .i_start (beat_start),
    .i_idx   (beat_idx),
    .i_mode  (o_mode),
    .o_col   (wr_col)
  );

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_act   <= 1'b0;
      wr_bank  <= '0;
      wr_start <= '0;
      wr_idx   <= '0;
      wr_ap    <= 1'b0;
    end else if (wr_beat) begin
      wr_act   <= !beat_last;
      wr_bank  <= beat_bank;
      wr_start <= beat_start;
      wr_idx   <= beat_idx + 1'b1;
      wr_ap    <= beat_ap;
    end else begin
      wr_act <= 1'b0;
    end
  end

  // beats with every byte masked never reach the array
  always_comb begin
    beat_in.bank  = beat_bank;
    beat_in.col   = wr_col;
    beat_in.be    = ~i_dqm;
    beat_in.data  = i_dq;
    fifo_in_valid = wr_beat && (i_dqm != '1);
    fifo_out_ready = !rd_act;
  end

  sdb_fifo #(
    .WIDTH ($bits(sdb_beat_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_valid (fifo_in_valid),
    .o_ready (fifo_in_ready),
    .i_data  (beat_in),
    .o_valid (fifo_out_valid),
    .i_ready (fifo_out_ready),
    .o_data  (beat_out)
  );

  always_ff @(posedge i_clock) begin
    if (fifo_out_valid && fifo_out_ready) begin
      for (int b = 0; b < NUM_BYTES; b++) begin
        if (beat_out.be[b]) begin
          mem[{beat_out.bank, beat_out.col}][b*BYTE_W +: BYTE_W] <=
            beat_out.data[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // write recovery countdown for auto-precharge
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rec_cnt  <= '0;
      rec_bank <= '0;
    end else if (wr_beat && beat_last && beat_ap) begin
      rec_cnt  <= WR_RECOVERY_CYC;
      rec_bank <= beat_bank;
    end else if (rec_cnt != '0) begin
      rec_cnt <= rec_cnt - 1'b1;
    end
  end

  // bank open state
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bank_open <= '0;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (is_act && (i_bank_select == BANK_W'(b))) begin
          o_bank_open[b] <= 1'b1;
        end else if (is_pre && (pre_all || (i_bank_select == BANK_W'(b)))) begin
          o_bank_open[b] <= 1'b0;
        end else if (rd_act && rd_last && rd_ap && !is_read && !is_write && !is_stop
                     && (rd_bank == BANK_W'(b))) begin
          o_bank_open[b] <= 1'b0;
        end else if ((rec_cnt == 2'h1) && (rec_bank == BANK_W'(b))) begin
          o_bank_open[b] <= 1'b0;
        end
      end
    end
  end

  // array read and latency pipeline
  always_ff @(posedge i_clock) begin
    s1_data <= mem[{rd_bank, rd_col}];
    s2_data <= s1_data;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_valid <= 1'b0;
      s2_valid <= 1'b0;
    end else begin
      s1_valid <= rd_act;
      s2_valid <= s1_valid;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dqm_d1 <= '1;
      dqm_d2 <= '1;
    end else begin
      dqm_d1 <= i_dqm;
      dqm_d2 <= dqm_d1;
    end
  end

  always_comb begin
    lat3       = (o_mode.cas_latency == CL_CODE_3);
    next_dq    = lat3 ? s2_data : s1_data;
    next_valid = lat3 ? s2_valid : s1_valid;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dq    <= '0;
      o_dq_oe <= '0;
    end else begin
      o_dq    <= next_dq;
      o_dq_oe <= {NUM_BYTES{next_valid}} & ~dqm_d2;
    end
  end

  // status
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_read_busy   <= 1'b0;
      o_write_busy  <= 1'b0;
      o_write_stall <= 1'b0;
    end else begin
      o_read_busy   <= rd_act;
      o_write_busy  <= wr_act || fifo_out_valid;
      o_write_stall <= !fifo_in_ready;
    end
  end

endmodule : sdb_core

/* File: tb/sdb_ctrl_model.sv */
// controller-side model driving the command and data pins
`timescale 1ns/10ps
module sdb_ctrl_model (
  input  wire logic                               i_clock,
  output logic                                    o_cke,
  output sdb_pkg::sdb_pins_s                      o_cmd,
  output logic         [sdb_pkg::BANK_W-1:0]      o_bank,
  output logic         [sdb_pkg::ADDR_W-1:0]      o_addr,
  output logic         [sdb_pkg::NUM_BYTES-1:0]   o_dqm,
  output logic         [sdb_pkg::DQ_W-1:0]        o_dq
);
  import sdb_pkg::*;
  initial begin
    o_cke  = 1'h1;
    o_cmd  = 4'h7;
    o_bank = 2'h0;
    o_addr = 13'h0;
    o_dqm  = 2'h0;
    o_dq   = 16'h0;
  end
  // one command per falling edge; released data lines toggle
  task automatic op(input logic [3:0] k, input logic [1:0] b, input logic [12:0] a,
                    input logic [15:0] d, input logic v, input logic [1:0] m);
    @(negedge i_clock);
    o_cmd  = k;
    o_bank = b;
    o_addr = a;
    o_dqm  = m;
    o_dq   = v ? d : ~o_dq;
  endtask : op
endmodule : sdb_ctrl_model

/* File: tb/sdb_core_props.sv */
// concurrent checks on the sdram core ports
`timescale 1ns/10ps
module sdb_core_props (
  input wire logic                          i_clock,
  input wire logic                          i_rst_b,
  input wire logic                          i_cke,
  input wire sdb_pkg::sdb_pins_s            i_cmd,
  input wire logic [sdb_pkg::BANK_W-1:0]    i_bank_select,
  input wire logic [sdb_pkg::ADDR_W-1:0]    i_addr,
  input wire logic [sdb_pkg::NUM_BYTES-1:0] i_dqm,
  input wire logic [sdb_pkg::DQ_W-1:0]      i_dq,
  input wire logic [sdb_pkg::DQ_W-1:0]      o_dq,
  input wire logic [sdb_pkg::NUM_BYTES-1:0] o_dq_oe,
  input wire logic [sdb_pkg::NUM_BANKS-1:0] o_bank_open,
  input wire sdb_pkg::sdb_mode_s            o_mode,
  input wire logic                          o_read_busy,
  input wire logic                          o_write_busy,
  input wire logic                          o_write_stall
);
  import sdb_pkg::*;
  logic       cke_q;
  logic       ok;
  logic       kill;
  logic [3:0] c;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cke_q <= 1'h0;
    end else begin
      cke_q <= i_cke;
    end
  end
  assign c    = i_cmd;
  assign ok   = i_cke && cke_q;
  assign kill = ok && (c == 4'h4 || c == 4'h2);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  AST_MRS_LOAD: assert property (ok && c == 4'h0 |=> o_mode == $past(i_addr[6:0]))
    else $error("mode not loaded from address");
  AST_CKE_GATE: assert property (!ok |=> $stable(o_mode))
    else $error("mode changed while gated");
  AST_PRE_ONE: assert property (ok && c == 4'h2 && !i_addr[10]
      |=> !o_bank_open[$past(i_bank_select)])
    else $error("bank still open after precharge");
  AST_PRE_ALL: assert property (ok && c == 4'h2 && i_addr[10] |=> o_bank_open == 4'h0)
    else $error("banks open after precharge all");
  AST_RD_CL2: assert property (ok && c == 4'h5 && o_mode.cas_latency == CL_CODE_2
      && i_dqm == 2'h0 ##1 !kill |-> ##2 o_dq_oe == 2'h3)
    else $error("no data two clocks after read");
  AST_RD_CL3: assert property (ok && c == 4'h5 && o_mode.cas_latency == CL_CODE_3
      && i_dqm == 2'h0 ##1 !kill && i_dqm == 2'h0 |-> ##3 o_dq_oe == 2'h3)
    else $error("no data three clocks after read");
  AST_DQM_RD: assert property (i_dqm == 2'h3 |-> ##3 o_dq_oe == 2'h0)
    else $error("masked read data driven");
  AST_STOP_FLOAT: assert property (ok && c == 4'h6 && o_mode.cas_latency == CL_CODE_2
      |-> ##3 o_dq_oe == 2'h0)
    else $error("data driven after burst stop");
  AST_WAP_CLOSE: assert property (ok && c == 4'h4 && i_addr[10]
      && o_mode.burst_len == BL_CODE_1 |-> ##3 !o_bank_open[$past(i_bank_select, 3)])
    else $error("bank open after write autoprecharge");
  AST_RD_BUSY: assert property (ok && c == 4'h5 |-> ##2 o_read_busy)
    else $error("read busy not raised");
  AST_WR_BUSY: assert property (ok && c == 4'h4 && i_dqm != 2'h3 |-> ##2 o_write_busy)
    else $error("write busy not raised");
  COV_MRS: cover property (ok && c == 4'h0);
  COV_RD: cover property (ok && c == 4'h5 ##3 o_dq_oe == 2'h3);
  COV_WAP: cover property (ok && c == 4'h4 && i_addr[10]);
endmodule : sdb_core_props
bind sdb_core sdb_core_props u_sdb_core_props (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cke(i_cke), .i_cmd(i_cmd),
  .i_bank_select(i_bank_select), .i_addr(i_addr), .i_dqm(i_dqm), .i_dq(i_dq),
  .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_bank_open(o_bank_open), .o_mode(o_mode),
  .o_read_busy(o_read_busy), .o_write_busy(o_write_busy), .o_write_stall(o_write_stall)
);

/* File: tb/testbench.sv */
// self-checking bench for the sdram core
`timescale 1ns/10ps
module testbench;
  import sdb_pkg::*;
  typedef struct packed {
    logic [6:0]  mode;
    logic [8:0]  col;
    logic [3:0]  n;
    logic [31:0] seq;
  } sdb_row_s;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] BST = 4'h6, PRE = 4'h2, MRS = 4'h0;
  localparam sdb_row_s ROWS [7] = '{
    '{7'h21, 9'h001, 4'h2, 32'h0000_0001}, '{7'h22, 9'h005, 4'h4, 32'h0000_4765},
    '{7'h3A, 9'h005, 4'h4, 32'h0000_6745}, '{7'h23, 9'h003, 4'h8, 32'h2107_6543},
    '{7'h3B, 9'h006, 4'h8, 32'h1032_5476}, '{7'h20, 9'h007, 4'h1, 32'h0000_0007},
    '{7'h29, 9'h002, 4'h2, 32'h0000_0032}};
  logic        clock;
  logic        rst_b;
  logic        cke;
  sdb_pins_s   cmd;
  logic [1:0]  bank;
  logic [12:0] addr;
  logic [1:0]  dqm;
  logic [15:0] dq;
  logic [15:0] rdq;
  logic [1:0]  oe;
  logic [3:0]  open;
  logic        rbusy;
  logic        wbusy;
  logic        stall;
  sdb_mode_s   mode;
  int          failures;
  int          n_tests;
  logic [15:0] q[$];
  sdb_core u_sdb_core (.i_clock(clock), .i_rst_b(rst_b), .i_cke(cke), .i_cmd(cmd),
    .i_bank_select(bank), .i_addr(addr), .i_dqm(dqm), .i_dq(dq), .o_dq(rdq),
    .o_dq_oe(oe), .o_bank_open(open), .o_mode(mode), .o_read_busy(rbusy),
    .o_write_busy(wbusy), .o_write_stall(stall));
  sdb_ctrl_model u_sdb_ctrl_model (.i_clock(clock), .o_cke(cke), .o_cmd(cmd),
    .o_bank(bank), .o_addr(addr), .o_dqm(dqm), .o_dq(dq));
  task automatic summarize;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk_dq(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_dq
  task automatic chk_fl(input string nm, input logic [6:0] e, input logic [6:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_fl
  task automatic op(input logic [3:0] k, input logic [1:0] b = 2'h0,
                    input logic [12:0] a = 13'h0, input logic [15:0] d = 16'h0,
                    input logic v = 1'h0, input logic [1:0] m = 2'h0);
    u_sdb_ctrl_model.op(k, b, a, d, v, m);
  endtask : op
  // idle clocks, then one beat per clock, then bus released
  task automatic run(input int cl, input logic [15:0] e[$]);
    for (int j = 1; j <= cl + e.size(); j++) begin
      op(NOP);
      if (j > cl) begin
        chk_dq("rdata", e[j-cl-1], rdq);
        chk_fl("oe", 7'h3, {5'h0, oe});
      end
    end
    op(NOP);
    chk_fl("oe_off", 7'h0, {5'h0, oe});
  endtask : run
  task automatic mode_set(input logic [6:0] m);
    op(PRE, 2'h0, 13'h400);
    op(MRS, 2'h0, {6'h0, m});
    op(NOP);
    op(NOP);
    op(ACT);
    op(NOP);
    op(NOP);
  endtask : mode_set
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize();
  end
  initial begin
    rst_b = 1'h0;
    repeat (6) @(posedge clock);
    @(negedge clock) rst_b = 1'h1;
    chk_fl("mode_rst", MODE_RST, mode);
    chk_fl("open_rst", 7'h0, {3'h0, open});
    u_sdb_ctrl_model.o_cke = 1'h0;
    op(MRS, 2'h0, 13'h033);
    u_sdb_ctrl_model.o_cke = 1'h1;
    op(NOP);
    chk_fl("mode_gated", MODE_RST, mode);
    mode_set(7'h23);
    for (int k = 0; k < 8; k++) op(k == 0 ? WR : NOP, 2'h0, 13'h0, 16'hA500 + k, 1'h1);
    repeat (4) op(NOP);
    foreach (ROWS[i]) begin
      mode_set(ROWS[i].mode);
      chk_fl("mode", ROWS[i].mode, mode);
      q = {};
      for (int k = 0; k < ROWS[i].n; k++) q.push_back(16'hA500 | ROWS[i].seq[4*k+:4]);
      op(RD, 2'h0, {4'h0, ROWS[i].col});
      run(ROWS[i].mode[6:4], q);
    end
    mode_set(7'h22);
    op(RD);
    op(RD, 2'h0, 13'h004);
    q = {16'hA500, 16'hA504, 16'hA505, 16'hA506, 16'hA507};
    run(1, q);
    mode_set(7'h23);
    op(RD);
    op(NOP);
    op(BST);
    q = {16'hA500, 16'hA501};
    run(0, q);
    chk_fl("open_stop", 7'h1, {3'h0, open});
    mode_set(7'h22);
    op(WR, 2'h0, 13'h0, 16'h1111, 1'h1);
    op(NOP, 2'h0, 13'h0, 16'h2222, 1'h1);
    op(WR, 2'h0, 13'h004, 16'h3344, 1'h1, 2'h2);
    op(NOP, 2'h0, 13'h0, 16'h5555, 1'h1);
    op(NOP, 2'h0, 13'h0, 16'h6666, 1'h1);
    op(NOP, 2'h0, 13'h0, 16'h7777, 1'h1);
    op(NOP, 2'h0, 13'h0, 16'h8888, 1'h1);
    repeat (4) op(NOP);
    mode_set(7'h23);
    op(RD);
    q = {16'h1111, 16'h2222, 16'hA502, 16'hA503, 16'hA544, 16'h5555, 16'h6666, 16'h7777};
    run(2, q);
    mode_set(7'h20);
    op(ACT, 2'h2);
    op(NOP);
    op(ACT, 2'h3);
    op(NOP);
    op(NOP);
    op(WR, 2'h2, 13'h400, 16'h9999, 1'h1);
    op(NOP);
    op(NOP);
    chk_fl("open_wr", 7'hD, {3'h0, open});
    chk_fl("wr_busy", 7'h1, {6'h0, wbusy});
    chk_fl("stall", 7'h0, {6'h0, stall});
    op(NOP);
    chk_fl("open_wap", 7'h9, {3'h0, open});
    op(RD, 2'h3, 13'h400, 16'h0, 1'h0, 2'h2);
    op(NOP);
    chk_fl("open_rd", 7'h9, {3'h0, open});
    op(NOP);
    chk_fl("open_rap", 7'h1, {3'h0, open});
    chk_fl("rd_busy", 7'h1, {6'h0, rbusy});
    op(NOP);
    chk_fl("oe_mask", 7'h1, {5'h0, oe});
    op(ACT, 2'h2);
    op(PRE);
    op(NOP);
    chk_fl("open_pre", 7'h4, {3'h0, open});
    op(RD, 2'h2, 13'h0, 16'h0, 1'h0, 2'h3);
    repeat (3) op(NOP);
    chk_fl("oe_mask_all", 7'h0, {5'h0, oe});
    summarize();
  end
endmodule : testbench
